/* hdl/smf_defines.svh */
// Register offsets, bit positions and reset values of the serial flag block.
`ifndef SMF_DEFINES_SVH
`define SMF_DEFINES_SVH
`define SMF_OFS_CTRL 4'h0
`define SMF_OFS_STAT 4'h4
`define SMF_BIT_MASTER 7
`define SMF_BIT_TRANSMIT_DIRECTION_FLAG 6
`define SMF_BIT_BEGIN 5
`define SMF_BIT_HALT 4
`define SMF_BIT_RESP 3
`define SMF_BIT_LOST 2
`define SMF_BIT_ACK 1
`define SMF_BIT_EVENT 0
`define SMF_CTRL_RESET 8'h00
`define SMF_STAT_SCL 0
`define SMF_STAT_SDA 1
`define SMF_STAT_ACKWR 2
`define SMF_STAT_DATWR 3
`define SMF_SYNC_STAGES 2
`endif

/* hdl/smf_pkg.sv */
// Types shared by the serial flag block and its helpers.
package smf_pkg;

  // Control and status flags, bit 7 down to bit 0.
  typedef struct packed {
    logic master;
    logic transmit_direction_flag;
    logic begin_condition_flag;
    logic halt_condition_flag;
    logic response_needed_flag;
    logic contention_lost_flag;
    logic ack;
    logic frame_event_flag;
  } smf_flags_t;

  // One-cycle events and levels from the byte engine on the same clock.
  typedef struct packed {
    logic start_gen;
    logic stop_gen;
    logic frame_begin;
    logic dat_write;
    logic byte_rcvd;
    logic byte_txd;
    logic ack_done;
    logic addr_rcvd;
    logic addressed;
    logic drive_one;
    logic in_ack;
    logic gen_attempt;
    logic receiving;
  } smf_evt_t;

  // Bus conditions found on the sampled lines.
  typedef struct packed {
    logic start_det;
    logic stop_det;
    logic scl;
    logic sda;
  } smf_line_t;

endpackage

/* hdl/smf_sync.sv */
// Two-stage synchroniser for the clock and data pins.
`timescale 1ns/100ps
module smf_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out
);
  import smf_pkg::*;

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  // Lines idle high, so both stages reset to one.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_out = sync_reg;
endmodule

/* hdl/smf_cond_det.sv */
// START and STOP detection on the synchronised bus lines.
`timescale 1ns/100ps
module smf_cond_det (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_s,
  input wire logic sda_s,
  output smf_pkg::smf_line_t line
);
  import smf_pkg::*;

  logic scl_reg;
  logic sda_reg;
  logic start_reg;
  logic stop_reg;
  wire logic start_next = scl_s && scl_reg && sda_reg && !sda_s;
  wire logic stop_next = scl_s && scl_reg && !sda_reg && sda_s;

  // Data moving while the clock stays high marks a START or a STOP.
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      scl_reg <= scl_s;
      sda_reg <= sda_s;
      start_reg <= start_next;
      stop_reg <= stop_next;
    end
  end

  assign line = '{start_det: start_reg, stop_det: stop_reg, scl: scl_reg, sda: sda_reg};
endmodule

/* hdl/smf_flags.sv */
// Control and status flags of a two-wire serial interface with a register port.
`timescale 1ns/100ps
`include "smf_defines.svh"
//
// Contract
// - Master flag sets when this device generates a START.
// - Master flag clears on generated STOP or lost arbitration.
// - Transmit flag sets on generated START or data written before a frame.
// - Transmit flag clears when a START is detected or arbitration lost.
// - Transmit flag clears when no data was written before a frame.
// - Begin flag sets on START plus address received; only software clears it.
// - Halt flag sets on STOP detected while addressed as slave.
// - Halt flag also sets when arbitration is lost to a detected STOP.
// - Halt flag clears once the requested STOP has been generated.
// - Response flag sets on byte received, clears after each acknowledge cycle.
// - Lost flag sets on unwanted repeated START as master, begin flag low.
// - Lost flag sets on clock line low while making STOP or repeated START.
// - Lost flag sets when a driven one reads low, acknowledge bits excepted.
// - Lost flag clears whenever software clears the frame event flag.
// - Transmitting: acknowledge bit records the inverted incoming acknowledge level.
// - Event flag sets on generated START, lost arbitration, or acknowledged byte.
// - Event flag sets when a byte is received.
// - Event flag sets on START plus slave address and direction received.
// - Event flag sets when a STOP is received (here only while addressed as slave and not master).
// - While the event flag is set, the clock line is held low.
// - Receiving: drive acknowledge if the bit is one, not-acknowledge if zero.
// - Clearing the event flag without writing acknowledge sends not-acknowledge.
module smf_flags (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_n,
  output logic sda_o,
  output logic sda_oe_n,
  input wire smf_pkg::smf_evt_t evt,
  output smf_pkg::smf_flags_t flags,
  output logic start_seen,
  output logic stop_seen
);
  import smf_pkg::*;

  // Address decode is shared by the read and the write path.
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic [1:0] pins_s;
  smf_line_t line;

  smf_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pin_in({sda_i, scl_i}),
    .pin_out(pins_s)
  );

  smf_cond_det u_det (
    .clk(clk),
    .srst(srst),
    .scl_s(pins_s[0]),
    .sda_s(pins_s[1]),
    .line(line)
  );

  smf_flags_t f_reg;
  smf_flags_t f_next;
  logic ack_wr_reg;
  logic ack_wr_next;
  logic dat_wr_reg;
  logic dat_wr_next;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic start_seen_reg;
  logic stop_seen_reg;

  // A bus access completes at the edge where waitrequest is seen low.
  wire logic req = avs_read || avs_write;
  wire logic done = req && !wait_reg;
  wire logic is_ctrl = hit(avs_address, `SMF_OFS_CTRL);
  wire logic is_stat = hit(avs_address, `SMF_OFS_STAT);
  wire logic wr_ctrl = done && avs_write && is_ctrl && avs_byteenable[0];
  wire logic [7:0] wd = avs_writedata[7:0];

  // Software clearing the event flag; it also clears the contention lost flag.
  wire logic sw_ev_clr = wr_ctrl && f_reg.frame_event_flag && !wd[`SMF_BIT_EVENT];

  // Contention sources.
  wire logic lost_rstart = line.start_det && f_reg.master &&
    !f_reg.begin_condition_flag && !evt.start_gen;
  wire logic lost_scl = evt.gen_attempt && !line.scl;
  wire logic lost_sda = evt.drive_one && !evt.in_ack && !line.sda;
  wire logic lost_stop = line.stop_det && f_reg.master && !evt.stop_gen;
  wire logic arb_lost = lost_rstart || lost_scl || lost_sda || lost_stop;

  // A received STOP matters to us only when we are the addressed slave.
  wire logic stop_rx = line.stop_det && evt.addressed && !f_reg.master;

  // Every hardware reason for a new frame event.
  wire logic ev_set = evt.start_gen || arb_lost || evt.byte_txd ||
    evt.byte_rcvd ||
    evt.addr_rcvd ||
    stop_rx;

  // Acknowledge value put on the line: an unwritten bit counts as zero.
  wire logic ack_eff = f_reg.ack && ack_wr_reg;

  // Next value of each flag; where set and clear meet, the set wins.
  always_comb begin
    f_next = f_reg;
    ack_wr_next = ack_wr_reg;
    dat_wr_next = dat_wr_reg;

    // Software writable bits first, so hardware events overrule them.
    if (wr_ctrl) begin
      f_next.begin_condition_flag = wd[`SMF_BIT_BEGIN];
      f_next.halt_condition_flag = wd[`SMF_BIT_HALT];
      f_next.ack = wd[`SMF_BIT_ACK];
      f_next.frame_event_flag = wd[`SMF_BIT_EVENT];
      ack_wr_next = 1'b1;
    end

    // Master state.
    if (evt.stop_gen || arb_lost) begin
      f_next.master = 1'b0;
    end
    if (evt.start_gen) begin
      f_next.master = 1'b1;
    end

    // Direction, decided at each frame from whether data was written.
    if (evt.dat_write) begin
      dat_wr_next = 1'b1;
    end
    if (line.start_det || arb_lost) begin
      f_next.transmit_direction_flag = 1'b0;
    end
    if (evt.frame_begin) begin
      f_next.transmit_direction_flag = dat_wr_reg;
      dat_wr_next = evt.dat_write;
    end
    if (evt.start_gen) begin
      f_next.transmit_direction_flag = 1'b1;
    end

    // Begin flag is set by hardware on address received, and by software writes.
    if (evt.addr_rcvd) begin
      f_next.begin_condition_flag = 1'b1;
    end

    // Halt flag.
    if (evt.stop_gen && f_reg.halt_condition_flag) begin
      f_next.halt_condition_flag = 1'b0;
    end
    if (stop_rx) begin
      f_next.halt_condition_flag = 1'b1;
    end
    if (lost_stop) begin
      f_next.halt_condition_flag = 1'b1;
    end

    // Response needed flag.
    if (evt.ack_done) begin
      f_next.response_needed_flag = 1'b0;
    end
    if (evt.byte_rcvd || evt.addr_rcvd) begin
      f_next.response_needed_flag = 1'b1;
      ack_wr_next = 1'b0;
    end

    // Contention flag follows the event flag's software clear.
    if (sw_ev_clr) begin
      f_next.contention_lost_flag = 1'b0;
    end
    if (arb_lost) begin
      f_next.contention_lost_flag = 1'b1;
    end

    // Incoming acknowledge while transmitting: low line means acknowledged.
    if (evt.byte_txd && !evt.receiving) begin
      f_next.ack = !line.sda;
    end

    // Event flag: a new event in the clearing cycle keeps it set.
    if (ev_set) begin
      f_next.frame_event_flag = 1'b1;
    end
  end

  // Flag and bookkeeping state.
  always_ff @(posedge clk) begin
    if (srst) begin
      f_reg <= `SMF_CTRL_RESET;
      ack_wr_reg <= 1'b0;
      dat_wr_reg <= 1'b0;
    end else begin
      f_reg <= f_next;
      ack_wr_reg <= ack_wr_next;
      dat_wr_reg <= dat_wr_next;
    end
  end

  // Read mux; unmapped addresses read zero and ignore writes.
  wire logic [31:0] stat_word = {28'h0000000, dat_wr_reg, ack_wr_reg, line.sda, line.scl};
  wire logic [31:0] ctrl_word = {24'h000000, f_reg};
  wire logic [31:0] rd_next = is_ctrl ? ctrl_word : (is_stat ? stat_word : 32'h00000000);

  // One wait state per access; idle waitrequest stays high.
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= !(req && wait_reg);
      if (req && wait_reg) begin
        rdata_reg <= rd_next;
      end
    end
  end

  // Line drivers. Loading the clock driver from the flag's next value keeps the
  // stall exact: it ends at the same edge where the flag clears.
  wire logic sda_pull = evt.in_ack && evt.receiving && ack_eff;
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else begin
      scl_oe_n_reg <= !f_next.frame_event_flag;
      sda_oe_n_reg <= !sda_pull;
      start_seen_reg <= line.start_det;
      stop_seen_reg <= line.stop_det;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign flags = f_reg;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign start_seen = start_seen_reg;
  assign stop_seen = stop_seen_reg;
endmodule

/* test/smf_flags_assertions.sv */
// Concurrent checks on the ports of the serial flag block.
`timescale 1ns/100ps
module smf_flags_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic scl_oe_n,
  input wire smf_pkg::smf_evt_t evt,
  input wire smf_pkg::smf_flags_t flags
);
  import smf_pkg::*;
  // A single clock domain, so the clock and reset are stated once.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Any accepted write may clear software-owned flags.
  wire sw_wr = avs_write && !avs_waitrequest;
  property p_rst; disable iff (1'b0) srst |=> flags == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("flags not clear after reset");
  property p_mset; evt.start_gen |=> flags.master; endproperty
  a_mset: assert property (p_mset) else $error("master not set");
  property p_mclr; evt.stop_gen && !evt.start_gen |=> !flags.master; endproperty
  a_mclr: assert property (p_mclr) else $error("master not cleared");
  property p_txset; evt.start_gen |=> flags.transmit_direction_flag; endproperty
  a_txset: assert property (p_txset) else $error("direction not set");
  property p_evstart; evt.start_gen |=> flags.frame_event_flag; endproperty
  a_evstart: assert property (p_evstart) else $error("event not set");
  property p_rx; evt.byte_rcvd |=> flags.frame_event_flag && flags.response_needed_flag; endproperty
  a_rx: assert property (p_rx) else $error("byte receipt not flagged");
  property p_rclr; evt.ack_done && !evt.byte_rcvd && !evt.addr_rcvd |=> !flags.response_needed_flag; endproperty
  a_rclr: assert property (p_rclr) else $error("response flag kept");
  // The clock driver is loaded from the flag's next value, so both change at one edge.
  property p_stall; 1 |-> scl_oe_n == !flags.frame_event_flag; endproperty
  a_stall: assert property (p_stall) else $error("clock stall wrong");
  property p_lclr; $fell(flags.frame_event_flag) |-> !flags.contention_lost_flag; endproperty
  a_lclr: assert property (p_lclr) else $error("lost flag kept");
  property p_bhold; flags.begin_condition_flag && !sw_wr |=> flags.begin_condition_flag; endproperty
  a_bhold: assert property (p_bhold) else $error("begin flag dropped");
endmodule
bind smf_flags smf_flags_assertions u_chk (.clk(clk), .srst(srst), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .scl_oe_n(scl_oe_n), .evt(evt), .flags(flags));

/* test/smf_bus_model.sv */
// Far-side bus party that makes START and STOP conditions.
`timescale 1ns/100ps
module smf_bus_model (
  input wire logic clk,
  output logic scl_low,
  output logic sda_low
);
  // Lines start released, so the pull-ups give an idle bus.
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Half of the 80 ns link period is four system clocks.
  task automatic half;
    repeat (4) @(posedge clk);
  endtask
  // Data falls while the clock is high, then the clock is held low.
  task automatic send_start;
    half;
    sda_low <= 1'b1;
    half;
    scl_low <= 1'b1;
    half;
  endtask
  // Data rises while the clock is high.
  task automatic send_stop;
    sda_low <= 1'b1;
    half;
    scl_low <= 1'b0;
    half;
    sda_low <= 1'b0;
    half;
  endtask
endmodule

/* test/smf_flags_tb_top.sv */
// Self-checking bench for the serial flag block.
`timescale 1ns/100ps
module smf_flags_tb_top;
  import smf_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, scl_oe_n, sda_oe_n, scl_low, sda_low;
  smf_evt_t ev = '0;
  smf_flags_t flags;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  smf_bus_model far (.clk(clk), .scl_low(scl_low), .sda_low(sda_low));
  // Open-drain lines: any party pulling low wins over the pull-up.
  wire scl_line = !scl_low && scl_oe_n;
  wire sda_line = !sda_low && sda_oe_n;
  smf_flags dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl_line),
    .sda_i(sda_line), .scl_o(), .scl_oe_n(scl_oe_n), .sda_o(), .sda_oe_n(sda_oe_n),
    .evt(ev), .flags(flags), .start_seen(), .stop_seen());
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // The request stands until waitrequest is seen low at a rising edge.
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Control flags checked both over the bus and at the flag port.
  task automatic cf(input logic [7:0] e);
    acc(0, 4'h0, 8'h00);
    chk(q, {24'h0, e});
    chk({24'h0, flags}, {24'h0, e});
  endtask
  // One-cycle event pulse; the flags land at the edge that takes it.
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    @(negedge clk);
  endtask
  // Levels are bit 4 addressed, 3 driving a one, 2 in acknowledge, 1 attempt, 0 receiving.
  task automatic lvl(input int i, input logic v);
    @(posedge clk);
    ev[i] <= v;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_reset;
    acc(1, 4'h8, 8'hFF);
    cf(8'h00);
  endtask
  task automatic t_master;
    pulse(12);
    cf(8'hC1);
    chk(scl_oe_n, 0);
    acc(1, 4'h0, 8'h10);
    cf(8'hD0);
    pulse(11);
    cf(8'h40);
  endtask
  // Addressed slave: the start clears the direction left by the master run.
  task automatic t_slave;
    lvl(4, 1'b1);
    far.send_start;
    pulse(5);
    cf(8'h29);
    acc(1, 4'h0, 8'h00);
    far.send_stop;
    repeat (4) @(negedge clk);
    cf(8'h19);
    acc(1, 4'h0, 8'h00);
    pulse(6);
    cf(8'h00);
    lvl(4, 1'b0);
  endtask
  task automatic t_dir;
    pulse(10);
    cf(8'h00);
    pulse(9);
    pulse(10);
    cf(8'h40);
    pulse(10);
    cf(8'h00);
  endtask
  task automatic t_rx;
    pulse(8);
    cf(8'h09);
    chk(scl_oe_n, 0);
    acc(1, 4'h0, 8'h02);
    lvl(0, 1'b1);
    lvl(2, 1'b1);
    chk(sda_oe_n, 0);
    pulse(6);
    cf(8'h02);
    lvl(2, 1'b0);
    pulse(8);
    acc(1, 4'h0, 8'h00);
    lvl(2, 1'b1);
    chk(sda_oe_n, 1);
    // The acknowledge cycle ends, so the response flag is down for the next test.
    pulse(6);
    lvl(2, 1'b0);
    lvl(0, 1'b0);
  endtask
  // A foreign start while master, then a held-low data and clock line.
  task automatic t_lost;
    pulse(12);
    acc(1, 4'h0, 8'h00);
    far.send_start;
    repeat (4) @(negedge clk);
    cf(8'h05);
    acc(1, 4'h0, 8'h00);
    cf(8'h00);
    lvl(3, 1'b1);
    cf(8'h05);
    lvl(3, 1'b0);
    acc(1, 4'h0, 8'h00);
    lvl(1, 1'b1);
    cf(8'h05);
    lvl(1, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_master;
    t_slave;
    t_dir;
    t_rx;
    t_lost;
    conclude;
  end
  // The sequence needs a few hundred cycles; a hang ends as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude;
    end
  end
endmodule
